//--- ubr_params.svh
// constants of the baud generator and receive fifo block: offsets, fields, resets
// assumes apb with 32-bit data, one aligned word per register
`ifndef UBR_PARAMS_SVH
`define UBR_PARAMS_SVH

// =====================================================================
// register offsets
`define UBR_OFS_DIV_LOW 8'h00
`define UBR_OFS_DIV_HIGH 8'h04
`define UBR_OFS_FMC 8'h08
`define UBR_OFS_RX_COUNT 8'h0C
`define UBR_OFS_CTRL 8'h10
`define UBR_OFS_STATUS 8'h14
`define UBR_OFS_RX_DATA 8'h18

// =====================================================================
// fifo_modulation_ctrl fields
`define UBR_FMC_THR_LSB 0
`define UBR_FMC_DIVISOR_RANGE_SELECT_BIT 2
`define UBR_FMC_UMOD_LSB 3

// =====================================================================
// control fields
`define UBR_CTRL_MEN_BIT 0
`define UBR_CTRL_REN_BIT 1
`define UBR_CTRL_RX_STOP_BITS_SELECT_BIT 2
`define UBR_CTRL_WLS_BIT 3
`define UBR_CTRL_PEN_BIT 4
`define UBR_CTRL_PTYPE_LSB 5
`define UBR_CTRL_RIE_BIT 7

// =====================================================================
// status fields
`define UBR_ST_RX_DATA_AVAILABLE_FLAG_BIT 0
`define UBR_ST_OVERRUN_ERROR_FLAG_BIT 1
`define UBR_ST_FERR_BIT 2
`define UBR_ST_PERR_BIT 3
`define UBR_ST_BIT8_BIT 4
`define UBR_ST_BUSY_BIT 5

// =====================================================================
// reset values, sizes and minimum divisors
`define UBR_RST_DIV_LOW 8'h00
`define UBR_RST_DIV_HIGH 8'h00
`define UBR_RST_FMC 6'h00
`define UBR_FIFO_DEPTH 3'h4
`define UBR_DIV_MIN_NORMAL 16'h0010
`define UBR_DIV_MIN_WIDE 16'h0008

`endif

//--- ubr_pkg.sv
// types of the baud generator and receive fifo block
// assumes ubr_params.svh for all numeric constants
package ubr_pkg;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } ubr_rx_state_t;

    typedef enum logic [1:0] {
        PAR_EVEN,
        PAR_ODD,
        PAR_MARK,
        PAR_SPACE
    } ubr_parity_t;

endpackage

//--- ubr_baud.sv
// bit timer with fractional modulation and three sample strobes
// assumes start_i is a one-cycle pulse on the first cycle of a start bit
`timescale 1ns/1ps

module ubr_baud (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic run_i,
    input wire logic [15:0] divisor_i,
    input wire logic [2:0] umod_i,
    input wire logic divisor_range_select_i,
    output logic sample_o,
    output logic bit_end_o
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0] acc;
        logic extra;
    } ubr_baud_state_t;

    ubr_baud_state_t state;
    ubr_baud_state_t next_state;
    logic [16:0] bit_len;
    logic [15:0] half;
    logic [3:0] sum;

    // =====================================================================
    // bit length and sample points
    always_comb begin
        bit_len = {1'b0, divisor_i} + {16'h0000, state.extra};
        half = {1'b0, divisor_i[15:1]};
        sum = {1'b0, state.acc} + {1'b0, umod_i};
        bit_end_o = run_i && ({1'b0, state.cnt} == bit_len - 17'h00001);
        if (divisor_range_select_i) begin
            sample_o = run_i && ((state.cnt == half - 16'h0001) || (state.cnt == half)
                || (state.cnt == half + 16'h0002));
        end else begin
            sample_o = run_i && ((state.cnt == half) || (state.cnt == half + 16'h0001)
                || (state.cnt == half + 16'h0002));
        end
    end

    // =====================================================================
    // counter and accumulator
    always_comb begin
        next_state = state;
        if (start_i) begin
            next_state.cnt = 16'h0000;
            next_state.acc = umod_i;
            next_state.extra = 1'b0;
        end else if (!run_i) begin
            next_state.cnt = 16'h0000;
        end else if (bit_end_o) begin
            next_state.cnt = 16'h0000;
            next_state.acc = sum[2:0];
            next_state.extra = sum[3];
        end else begin
            next_state.cnt = state.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

endmodule

//--- ubr_top.sv
// receive path of the serial port: divisor registers, bit timer, receiver,
// four-byte receive fifo and apb register slave
// assumes rx_i is asynchronous to clock_i and idles high
`timescale 1ns/1ps
`include "ubr_params.svh"

module ubr_top (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_i,
    output logic irq_o
);

    typedef struct packed {
        logic [7:0] div_low;
        logic [7:0] div_high;
        logic [15:0] divisor;
        logic [2:0] umod;
        logic divisor_range_select;
        logic [1:0] thr;
        logic men;
        logic ren;
        logic rx_stop_bits_select;
        logic wls;
        logic pen;
        logic [1:0] ptype;
        logic rx_interrupt_enable;
        logic overrun_error_flag;
        logic ferr;
        logic perr;
        logic bit8;
        logic [3:0][7:0] fifo;
        logic [1:0] rd_ptr;
        logic [2:0] level;
        logic [8:0] hold;
        logic hold_v;
        ubr_pkg::ubr_rx_state_t rx_state;
        logic [3:0] bit_idx;
        logic [8:0] shift;
        logic [1:0] votes;
        logic frame_bad;
        logic [1:0] sync;
        logic rx_prev;
        logic ack;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } ubr_state_t;

    ubr_state_t state;
    ubr_state_t next_state;

    logic line;
    logic start_pulse;
    logic timer_run;
    logic sample;
    logic bit_end;
    logic access;
    logic commit;
    logic rx_data_available_flag;
    logic [3:0] last_idx;
    logic [31:0] rd_value;
    logic mapped;
    logic voted;
    logic par_calc;
    logic [8:0] frame;
    logic popped;
    logic [2:0] lvl;
    logic [1:0] rptr;

    // =====================================================================
    // helpers
    function automatic logic ubr_majority(input logic [1:0] ones);
        // all three samples of the bit are counted in ones by the bit end
        ubr_majority = ones >= 2'h2;
    endfunction

    function automatic logic ubr_reaches(input logic [2:0] level, input logic [1:0] thr);
        // threshold code 00 means a full fifo
        if (thr == 2'b00) begin
            ubr_reaches = level >= `UBR_FIFO_DEPTH;
        end else begin
            ubr_reaches = level >= {1'b0, thr};
        end
    endfunction

    // =====================================================================
    // bit timer
    ubr_baud u_baud (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .start_i(start_pulse),
        .run_i(timer_run),
        .divisor_i(state.divisor),
        .umod_i(state.umod),
        .divisor_range_select_i(state.divisor_range_select),
        .sample_o(sample),
        .bit_end_o(bit_end)
    );

    // =====================================================================
    // line watch and frame shape
    always_comb begin
        line = state.sync[1];
        start_pulse = (state.rx_state == ubr_pkg::RX_IDLE) && state.men && state.ren
            && state.rx_prev && !line;
        timer_run = state.rx_state != ubr_pkg::RX_IDLE;
        // payload is 8 or 9 bits; with parity the last of them is the parity bit
        last_idx = state.wls ? 4'h8 : 4'h7;
        access = psel_i && penable_i;
        commit = access && state.ack;
        rx_data_available_flag = ubr_reaches(state.level, state.thr);
        voted = ubr_majority(state.votes);
        frame = state.wls ? {voted, state.shift[8:1]} : {1'b0, voted, state.shift[8:2]};
    end

    // =====================================================================
    // parity of the payload without its last bit
    always_comb begin
        if (state.wls) begin
            par_calc = ^frame[7:0];
        end else begin
            par_calc = ^frame[6:0];
        end
        unique case (ubr_pkg::ubr_parity_t'(state.ptype))
            ubr_pkg::PAR_EVEN: par_calc = par_calc;
            ubr_pkg::PAR_ODD: par_calc = !par_calc;
            ubr_pkg::PAR_MARK: par_calc = 1'b1;
            ubr_pkg::PAR_SPACE: par_calc = 1'b0;
        endcase
    end

    // =====================================================================
    // register read mux
    always_comb begin
        rd_value = 32'h00000000;
        mapped = 1'b1;
        unique case (paddr_i)
            `UBR_OFS_DIV_LOW: rd_value[7:0] = state.div_low;
            `UBR_OFS_DIV_HIGH: rd_value[7:0] = state.div_high;
            `UBR_OFS_FMC: rd_value[5:0] = {state.umod, state.divisor_range_select, state.thr};
            `UBR_OFS_RX_COUNT: rd_value[2:0] = state.level;
            `UBR_OFS_CTRL: rd_value[7:0] = {state.rx_interrupt_enable, state.ptype, state.pen, state.wls,
                state.rx_stop_bits_select, state.ren, state.men};
            `UBR_OFS_STATUS: rd_value[5:0] = {timer_run, state.bit8, state.perr, state.ferr,
                state.overrun_error_flag, rx_data_available_flag};
            `UBR_OFS_RX_DATA: rd_value[7:0] = state.fifo[state.rd_ptr];
            default: mapped = 1'b0;
        endcase
    end

    // =====================================================================
    // next state
    always_comb begin
        next_state = state;
        popped = 1'b0;

        // two-flop synchroniser on the serial input
        next_state.sync = {state.sync[0], rx_i};
        next_state.rx_prev = line;

        // apb: one wait cycle, effect and data at the pready edge
        next_state.ack = access && !state.ack;
        next_state.pslverr = access && !state.ack && !mapped;
        if (access && !state.ack) begin
            next_state.prdata = rd_value;
        end

        if (commit && pwrite_i && mapped) begin
            unique case (paddr_i)
                `UBR_OFS_DIV_LOW: next_state.div_low = pwdata_i[7:0];
                `UBR_OFS_DIV_HIGH: begin
                    // the high byte write loads the whole divisor
                    next_state.div_high = pwdata_i[7:0];
                    next_state.divisor = {pwdata_i[7:0], state.div_low};
                end
                `UBR_OFS_FMC: begin
                    next_state.thr = pwdata_i[`UBR_FMC_THR_LSB +: 2];
                    next_state.divisor_range_select = pwdata_i[`UBR_FMC_DIVISOR_RANGE_SELECT_BIT];
                    next_state.umod = pwdata_i[`UBR_FMC_UMOD_LSB +: 3];
                end
                `UBR_OFS_CTRL: begin
                    next_state.men = pwdata_i[`UBR_CTRL_MEN_BIT];
                    next_state.ren = pwdata_i[`UBR_CTRL_REN_BIT];
                    next_state.rx_stop_bits_select = pwdata_i[`UBR_CTRL_RX_STOP_BITS_SELECT_BIT];
                    next_state.wls = pwdata_i[`UBR_CTRL_WLS_BIT];
                    next_state.pen = pwdata_i[`UBR_CTRL_PEN_BIT];
                    next_state.ptype = pwdata_i[`UBR_CTRL_PTYPE_LSB +: 2];
                    next_state.rx_interrupt_enable = pwdata_i[`UBR_CTRL_RIE_BIT];
                end
                `UBR_OFS_STATUS: begin
                    // write one to clear; a new error in the same cycle wins below
                    if (pwdata_i[`UBR_ST_OVERRUN_ERROR_FLAG_BIT]) begin
                        next_state.overrun_error_flag = 1'b0;
                    end
                    if (pwdata_i[`UBR_ST_FERR_BIT]) begin
                        next_state.ferr = 1'b0;
                    end
                    if (pwdata_i[`UBR_ST_PERR_BIT]) begin
                        next_state.perr = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // a read of the data word takes one byte out
        if (commit && !pwrite_i && (paddr_i == `UBR_OFS_RX_DATA) && (state.level != 3'h0)) begin
            popped = 1'b1;
            next_state.rd_ptr = state.rd_ptr + 2'h1;
            next_state.level = state.level - 3'h1;
        end
        lvl = next_state.level;
        rptr = next_state.rd_ptr;

        // a byte waiting in the shift register refills the freed slot
        if (popped && state.hold_v) begin
            next_state.fifo[rptr + lvl[1:0]] = state.hold[7:0];
            next_state.bit8 = state.hold[8];
            next_state.hold_v = 1'b0;
            lvl = lvl + 3'h1;
            next_state.level = lvl;
        end

        // receiver
        unique case (state.rx_state)
            ubr_pkg::RX_IDLE: begin
                next_state.votes = 2'h0;
                if (start_pulse) begin
                    next_state.rx_state = ubr_pkg::RX_START;
                    next_state.bit_idx = 4'h0;
                    next_state.frame_bad = 1'b0;
                end
            end
            ubr_pkg::RX_START: begin
                if (bit_end) begin
                    next_state.votes = 2'h0;
                    // a start bit that votes high was noise
                    next_state.rx_state = voted ? ubr_pkg::RX_IDLE : ubr_pkg::RX_DATA;
                end
            end
            ubr_pkg::RX_DATA: begin
                if (bit_end) begin
                    next_state.votes = 2'h0;
                    next_state.shift = {voted, state.shift[8:1]};
                    next_state.bit_idx = state.bit_idx + 4'h1;
                    if (state.bit_idx == last_idx) begin
                        next_state.rx_state = ubr_pkg::RX_STOP;
                        next_state.bit_idx = 4'h0;
                        if (state.pen && (voted != par_calc)) begin
                            next_state.perr = 1'b1;
                        end
                    end
                end
            end
            ubr_pkg::RX_STOP: begin
                if (bit_end) begin
                    next_state.votes = 2'h0;
                    next_state.bit_idx = state.bit_idx + 4'h1;
                    if (!voted) begin
                        next_state.frame_bad = 1'b1;
                    end
                    // second stop bit only when selected
                    if (!state.rx_stop_bits_select || (state.bit_idx == 4'h1)) begin
                        next_state.rx_state = ubr_pkg::RX_IDLE;
                        if (!voted || state.frame_bad) begin
                            next_state.ferr = 1'b1;
                        end
                        if (lvl < `UBR_FIFO_DEPTH) begin
                            next_state.fifo[rptr + lvl[1:0]] = state.shift[7:0];
                            next_state.bit8 = state.shift[8];
                            next_state.level = lvl + 3'h1;
                        end else begin
                            // fifth waits in the shift register, sixth overwrites it
                            if (next_state.hold_v) begin
                                next_state.overrun_error_flag = 1'b1;
                            end
                            next_state.hold = state.shift;
                            next_state.hold_v = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (sample && (state.rx_state != ubr_pkg::RX_IDLE) && !bit_end && line) begin
            next_state.votes = state.votes + 2'h1;
        end

        // right-align the 8-bit payload into the low bits
        if ((state.rx_state == ubr_pkg::RX_STOP) && !state.wls) begin
            next_state.shift = state.shift;
        end
        if ((state.rx_state == ubr_pkg::RX_DATA) && bit_end && (state.bit_idx == last_idx)
            && !state.wls) begin
            next_state.shift = {1'b0, voted, state.shift[8:2]};
        end

        // receiver disabled aborts a frame
        if (!state.ren || !state.men) begin
            next_state.rx_state = ubr_pkg::RX_IDLE;
        end
        // master disable empties the fifo and clears the flags
        // judged on the new enable so that a write setting it keeps rx enable
        if (!next_state.men) begin
            next_state.level = 3'h0;
            next_state.rd_ptr = 2'h0;
            next_state.hold_v = 1'b0;
            next_state.overrun_error_flag = 1'b0;
            next_state.ferr = 1'b0;
            next_state.perr = 1'b0;
            next_state.ren = 1'b0;
        end

        next_state.irq = next_state.rx_interrupt_enable
            && (ubr_reaches(next_state.level, next_state.thr) || next_state.overrun_error_flag);
    end

    // =====================================================================
    // state register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= '0;
            state.div_low <= `UBR_RST_DIV_LOW;
            state.div_high <= `UBR_RST_DIV_HIGH;
            state.sync <= 2'b11;
            state.rx_prev <= 1'b1;
            state.rx_state <= ubr_pkg::RX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // outputs
    always_comb begin
        prdata_o = state.prdata;
        pready_o = state.ack;
        pslverr_o = state.pslverr;
        irq_o = state.irq;
    end

endmodule

//--- ubr_sva.sv
// checker: apb timing, read values and irq gating of the receive block
// assumes one clock domain, bound to ubr_top
`timescale 1ns/1ps
`include "ubr_params.svh"
module ubr_sva (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic rx_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic rd;
    assign rd = pready_o && !pwrite_i;
    // ====
    // assertions
    AST_ONE_WAIT: assert property ($rose(psel_i && penable_i) |-> !pready_o ##1 pready_o)
        else $error("ready not in second access cycle");
    AST_ONE_CYCLE: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    AST_IDLE_QUIET: assert property (!(psel_i && penable_i) |-> !pready_o)
        else $error("ready outside access phase");
    AST_ERR_PLACE: assert property (pslverr_o |-> pready_o && paddr_i > 8'h18)
        else $error("error on mapped address");
    AST_UNMAPPED: assert property (pready_o && paddr_i > 8'h18
        |-> pslverr_o && (!rd || prdata_o == 32'h0))
        else $error("unmapped access not refused");
    AST_UPPER_ZERO: assert property (rd |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_LEVEL_CAP: assert property (rd && paddr_i == `UBR_OFS_RX_COUNT
        |-> prdata_o <= 32'h4)
        else $error("level above four");
    AST_FMC_UNUSED: assert property (rd && paddr_i == `UBR_OFS_FMC
        |-> prdata_o[7:6] == 2'h0)
        else $error("unused control bits set");
    AST_IRQ_GATE: assert property (rd && paddr_i == `UBR_OFS_CTRL && !prdata_o[7]
        |-> !irq_o)
        else $error("irq without enable");
    AST_RESET_CLEAN: assert property ($rose(reset_n_i) |-> !pready_o && !irq_o)
        else $error("outputs busy after reset");
    COV_POP: cover property (rd && paddr_i == `UBR_OFS_RX_DATA);
    COV_ERR: cover property (pslverr_o);
    COV_IRQ: cover property ($rose(irq_o));
endmodule
bind ubr_top ubr_sva u_sva (.clock_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_i, .irq_o);

//--- ubr_line_model.sv
// remote transmitter driving the serial line
// assumes the line idles high between frames
`timescale 1ns/1ps
module ubr_line_model (
    input wire logic clock_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // start, nb payload bits lsb first, ns stop bits
    task automatic send(input logic [8:0] pay, input int nb, input int ns,
        input int dv, input logic [2:0] umod);
        logic [2:0] acc;
        logic cy;
        acc = 3'h0;
        @(posedge clock_i);
        for (int i = 0; i <= nb + ns; i++) begin
            line_o <= (i == 0) ? 1'b0 : (i <= nb) ? pay[i - 1] : 1'b1;
            {cy, acc} = acc + umod;
            repeat (dv + cy) @(posedge clock_i);
        end
    endtask
endmodule

//--- testbench.sv
// self-checking bench of the receive block
// assumes ubr_top behind apb and ubr_line_model on rx
`timescale 1ns/1ps
`include "ubr_params.svh"
module testbench;
    localparam logic [7:0] A_LO = `UBR_OFS_DIV_LOW;
    localparam logic [7:0] A_HI = `UBR_OFS_DIV_HIGH;
    localparam logic [7:0] A_FM = `UBR_OFS_FMC;
    localparam logic [7:0] A_CN = `UBR_OFS_RX_COUNT;
    localparam logic [7:0] A_CT = `UBR_OFS_CTRL;
    localparam logic [7:0] A_ST = `UBR_OFS_STATUS;
    localparam logic [7:0] A_DT = `UBR_OFS_RX_DATA;
    logic clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr, rx, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int n_fail = 0;
    int n_checks = 0;
    ubr_top uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_i(rx), .irq_o(irq));
    ubr_line_model m (.clock_i(clock_i), .line_o(rx));
    initial begin
        clock_i = 0;
        forever #2.5 clock_i = ~clock_i;
    end
    // ====
    // bus and compare tasks
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1;
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic frame(input logic [8:0] p, input int nb, input int ns, input int dv,
        input logic [2:0] um);
        m.send(p, nb, ns, dv, um);
        for (int k = 0; k < 40; k++) begin
            apb(0, A_ST, 32'h0);
            if (q[5] === 1'b0) break;
        end
    endtask
    // ====
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
        apb(1, 8'h1C, 32'hFF);
        apb(0, 8'h1C, 32'h0);
        chk({q[30:0], e}, 32'h1);
    endtask
    task automatic t_basic();
        apb(1, A_LO, 32'h10);
        apb(1, A_HI, 32'h00);
        apb(1, A_FM, 32'h19);
        apb(1, A_CT, 32'h83);
        frame(9'h0A5, 8, 1, 16, 3'h3);
        rchk(A_CN, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rchk(A_DT, 32'hA5);
        rchk(A_CN, 32'h0);
    endtask
    task automatic t_fill();
        logic [7:0] ex[5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h66};
        for (int k = 1; k <= 6; k++) begin
            frame(9'(k * 17), 8, 1, 16, 3'h3);
            for (int c = 0; c < 4; c++) begin
                apb(1, A_FM, 32'h18 | c);
                apb(0, A_ST, 32'h0);
                chk({31'h0, q[0]}, (c == 0) ? k >= 4 : k >= c);
            end
            rchk(A_CN, (k > 4) ? 4 : k);
        end
        apb(0, A_ST, 32'h0);
        chk({31'h0, q[1]}, 32'h1);
        apb(1, A_FM, 32'h19);
        foreach (ex[i]) rchk(A_DT, ex[i]);
        rchk(A_CN, 32'h0);
    endtask
    task automatic t_disable();
        frame(9'h05A, 8, 1, 16, 3'h3);
        rchk(A_CN, 32'h1);
        apb(1, A_CT, 32'h0);
        rchk(A_CN, 32'h0);
        rchk(A_ST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1, A_CT, 32'h83);
        frame(9'h05A, 8, 1, 16, 3'h3);
        rchk(A_CN, 32'h1);
        // reset in mid-run empties the fifo and restores the format
        reset_n_i <= 0;
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1;
        @(posedge clock_i);
        rchk(A_CN, 32'h0);
        rchk(A_CT, 32'h0);
    endtask
    task automatic t_format();
        apb(1, A_LO, 32'h08);
        apb(1, A_HI, 32'h00);
        apb(1, A_FM, 32'h05);
        apb(1, A_CT, 32'h0F);
        frame(9'h1C3, 9, 2, 8, 3'h0);
        apb(0, A_ST, 32'h0);
        chk({31'h0, q[4]}, 32'h1);
        rchk(A_DT, 32'hC3);
    endtask
    task automatic t_parity();
        logic p;
        for (int i = 0; i < 5; i++) begin
            apb(1, A_CT, 32'h13 | ((i % 4) << 5));
            p = (i % 4 == 0) ? ^7'h35 : (i % 4 == 1) ? ~^7'h35 : (i % 4 == 2);
            frame({1'b0, p ^ (i == 4), 7'h35}, 8, 1, 8, 3'h0);
            apb(0, A_ST, 32'h0);
            chk({31'h0, q[3]}, i == 4);
            apb(1, A_ST, 32'h08);
            if (i < 4) rchk(A_DT, {24'h0, p, 7'h35});
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial begin
        reset_n_i = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge clock_i);
        reset_n_i <= 1;
        @(posedge clock_i);
        t_reset();
        t_basic();
        t_fill();
        t_disable();
        t_format();
        t_parity();
        complete_run();
    end
endmodule
